/* hw/sfim_pkg.sv */
// Notes on behaviour
// R1: Completion of the sequencer, diagnostics or calibration sets a sticky flag that a status read clears.
// R2: A supply droop below the chosen threshold sets a latched flag that only a status read clears.
// R3: Over-temperature sets a flag that stays set after the condition goes until a status read clears it.
// R4: Overcurrent on either output terminal sets a sticky flag cleared by a status read.
// R5: The event mask acts only while the shared pin is in interrupt duty and is ignored otherwise.
// R6: A set mask bit blocks its flag: bit 0 overcurrent, 1 thermal, 2 droop, 3 completion, 4 format error.
// R7: The mask field resets to decimal 24 and the three reserved bits above it reset to zero.
// R8: After diagnostics the measured actuator impedance is shown as an eight-bit read-only value.
// R9: A continuously updated eight-bit read-only supply voltage reading is provided; the code updates it only from samples taken while waveformPlaying is high.
// R10: Supply samples are taken only while a waveform plays, so the host reads during playback.
// R11: A waveform memory format violation during playback sets a flag sticky until a status read.
// R12: In interrupt duty the pin is pulled low while any unmasked flag is set and released once cleared.
package sfim_pkg;

  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_MASK = 8'h02;
  localparam logic [7:0] OFS_IMPEDANCE = 8'h03;
  localparam logic [7:0] OFS_SUPPLY = 8'h04;

  // Status field positions
  localparam int BIT_OVERCURRENT = 0;
  localparam int BIT_THERMAL = 1;
  localparam int BIT_DROOP = 2;
  localparam int BIT_DONE = 3;
  localparam int BIT_FORMAT = 4;
  localparam int BIT_DIAG_FAIL = 7;
  localparam int FLAG_COUNT = 5;

  // Sticky clear-on-read bits of the status register
  localparam logic [7:0] STATUS_STICKY = 8'h9f;
  // Plain read/write reserved bits of the status register
  localparam logic [7:0] STATUS_RW = 8'h60;

  // Mask register layout
  localparam int MASK_WIDTH = 5;
  localparam logic [7:0] MASK_FIELD = 8'h1f;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_MASK = 8'h18;
  localparam logic [7:0] RST_IMPEDANCE = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_UNMAPPED = 8'h00;

  // Analog detector inputs that need synchronising
  localparam int DET_COUNT = 3;
  localparam int DET_OVERCURRENT = 0;
  localparam int DET_THERMAL = 1;
  localparam int DET_DROOP = 2;

  typedef logic [7:0] sfim_byte_t;

endpackage : sfim_pkg

/* hw/sfim_pin_sync.sv */
`timescale 1ns/1ps
// Three-stage synchroniser with agreement filter for detector levels
module sfim_pin_sync
  import sfim_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Asynchronous detector levels
  input wire logic [sfim_pkg::DET_COUNT-1:0] pinIn,
  // Filtered levels in the clock domain
  output logic [sfim_pkg::DET_COUNT-1:0] levelOut
);

  logic [DET_COUNT-1:0] stage1_q;
  logic [DET_COUNT-1:0] stage2_q;
  logic [DET_COUNT-1:0] stage3_q;
  logic [DET_COUNT-1:0] level_q;
  logic [DET_COUNT-1:0] agree;
  logic [DET_COUNT-1:0] level_d;

  // Change taken only when stages two and three agree
  assign agree = ~(stage2_q ^ stage3_q);
  assign level_d = (agree & stage3_q) | (~agree & level_q);
  assign levelOut = level_q;

  // Synchroniser chain
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end

endmodule : sfim_pin_sync

/* hw/sfim_status_irq.sv */
`timescale 1ns/1ps
// Status flags, event mask, result registers and interrupt pin drive
module sfim_status_irq
  import sfim_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,

  // Register port from the serial control bus
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output sfim_pkg::sfim_byte_t regRdData,
  output logic regRdValid,

  // Analog detector levels, asynchronous to the clock
  input wire logic overcurrentDetect,
  input wire logic thermalDetect,
  input wire logic droopDetect,

  // Event pulses from on-clock engines
  input wire logic sequencerDone,
  input wire logic diagDone,
  input wire logic calibrationDone,
  input wire logic diagFail,
  input wire logic formatError,

  // Measurement results from on-clock engines
  input wire logic [7:0] impedanceValue,
  input wire logic impedanceValid,
  input wire logic [7:0] supplySample,
  input wire logic supplySampleValid,
  input wire logic waveformPlaying,

  // Pin function selection, high in interrupt duty
  input wire logic irqModeEn,

  // Open-drain trigger or interrupt pin
  output logic trigIrqPinOut,
  output logic trigIrqPinOe,

  // Current flags and interrupt pending state for neighbouring logic
  output logic [sfim_pkg::FLAG_COUNT-1:0] flagsOut,
  output logic irqPending
);

  import sfim_pkg::*;

  // Register storage
  sfim_byte_t status_q;
  sfim_byte_t status_d;
  sfim_byte_t mask_q;
  sfim_byte_t mask_d;
  sfim_byte_t impedance_q;
  sfim_byte_t impedance_d;
  sfim_byte_t supply_q;
  sfim_byte_t supply_d;
  sfim_byte_t rdData_q;
  sfim_byte_t rdData_d;
  logic rdValid_q;
  logic pinOe_q;
  logic pinOe_d;
  logic pinOut_q;
  logic [FLAG_COUNT-1:0] flagsOut_q;
  logic irqPending_q;

  // Synchronised detector levels
  logic [DET_COUNT-1:0] detRaw;
  logic [DET_COUNT-1:0] detLevel;

  // Address decode
  logic hitStatus;
  logic hitMask;
  logic hitImpedance;
  logic hitSupply;
  logic hitAny;
  logic statusWrite;
  logic maskWrite;
  logic [FLAG_COUNT-1:0] flagsNext;

  // Event and clear terms
  sfim_byte_t setBits;
  sfim_byte_t clearBits;
  logic statusRead;
  logic processDone;
  logic [FLAG_COUNT-1:0] liveFlags;
  logic [FLAG_COUNT-1:0] liveMask;
  logic [FLAG_COUNT-1:0] unmasked;
  logic anyUnmasked;
  logic supplyTake;

  // Compare an address against a register offset
  function automatic logic addrHit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    addrHit = (addr == ofs);
  endfunction : addrHit

  // Sticky update: kept unless cleared, a set term always wins
  function automatic sfim_byte_t stickyNext(input sfim_byte_t cur,
                                            input sfim_byte_t setv,
                                            input sfim_byte_t clr);
    stickyNext = (cur & ~clr) | (setv & STATUS_STICKY);
  endfunction : stickyNext

  // Bring analog detector levels into the clock domain
  // Levels need two agreeing samples, so a pulse shorter
  // than two cycles may never reach a flag
  assign detRaw[DET_OVERCURRENT] = overcurrentDetect;
  assign detRaw[DET_THERMAL] = thermalDetect;
  assign detRaw[DET_DROOP] = droopDetect;

  sfim_pin_sync uSync (
    .clock(clock),
    .rst(rst),
    .pinIn(detRaw),
    .levelOut(detLevel)
  );

  // Register address decode
  assign hitStatus = addrHit(regAddr, OFS_STATUS);
  assign hitMask = addrHit(regAddr, OFS_MASK);
  assign hitImpedance = addrHit(regAddr, OFS_IMPEDANCE);
  assign hitSupply = addrHit(regAddr, OFS_SUPPLY);
  assign hitAny = hitStatus | hitMask | hitImpedance | hitSupply;

  // Write strobes per register, other offsets ignore writes
  assign statusWrite = regWrEn & hitStatus;
  assign maskWrite = regWrEn & hitMask;

  // A status read clears the sticky bits it has returned
  assign statusRead = regRdEn & hitStatus;
  assign clearBits = statusRead ? STATUS_STICKY : 8'h00;

  // Any of the three engines finishing counts as done
  // R1: completion event
  assign processDone = sequencerDone | diagDone | calibrationDone;

  // Hardware set terms for each sticky bit
  always_comb begin
    setBits = 8'h00;
    // R4: overcurrent sets
    setBits[BIT_OVERCURRENT] = detLevel[DET_OVERCURRENT];
    // R3: over-temperature sets
    setBits[BIT_THERMAL] = detLevel[DET_THERMAL];
    // R2: supply droop sets
    setBits[BIT_DROOP] = detLevel[DET_DROOP];
    setBits[BIT_DONE] = processDone;
    // R11: format error sets
    setBits[BIT_FORMAT] = formatError;
    setBits[BIT_DIAG_FAIL] = diagFail;
  end

  // Status next value: set wins over the read clear
  // An event in the cycle of the read is kept for the next
  // read rather than lost between the answer and the clear
  always_comb begin
    status_d = status_q;
    // R1: clear on read
    status_d = stickyNext(status_q, setBits, clearBits);
    if (statusWrite) begin
      status_d = (status_d & ~STATUS_RW) | (regWrData & STATUS_RW);
    end
  end

  // Mask register write, all eight bits stored
  // R7: mask reset and reserved bits
  assign mask_d = maskWrite ? regWrData : mask_q;

  // Impedance result captured when diagnostics report it
  // R8: impedance capture
  assign impedance_d = impedanceValid ? impedanceValue : impedance_q;

  // Supply reading follows samples taken during playback only
  // R10: sample only while playing
  assign supplyTake = supplySampleValid & waveformPlaying;
  // R9: live supply reading
  assign supply_d = supplyTake ? supplySample : supply_q;

  // Read data mux, unmapped offsets read as zero
  always_comb begin
    rdData_d = rdData_q;
    if (regRdEn) begin
      if (hitStatus) begin
        rdData_d = status_q;
      end else if (hitMask) begin
        rdData_d = mask_q;
      end else if (hitImpedance) begin
        rdData_d = impedance_q;
      end else if (hitSupply) begin
        rdData_d = supply_q;
      end else if (!hitAny) begin
        rdData_d = RST_UNMAPPED;
      end
    end
  end

  // Flag and mask views in the documented bit order
  assign liveFlags = status_q[FLAG_COUNT-1:0];
  assign liveMask = mask_q[MASK_WIDTH-1:0];

  // R6: mask bit blocks flag
  assign unmasked = liveFlags & ~liveMask;
  assign anyUnmasked = |unmasked;

  // Pin pulled low only in interrupt duty with an unmasked flag
  // Bit 7 never reaches the pin; pin follows flags a cycle late
  // R5: mask only in irq duty
  // R12: drive pin low
  assign pinOe_d = irqModeEn & anyUnmasked;

  // Status register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_q <= RST_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Mask register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= RST_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Impedance result register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      impedance_q <= RST_IMPEDANCE;
    end else begin
      impedance_q <= impedance_d;
    end
  end

  // Supply reading register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supply_q <= RST_SUPPLY;
    end else begin
      supply_q <= supply_d;
    end
  end

  // Read data, held until the next read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_q <= RST_UNMAPPED;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  // Read answer strobe, one cycle after the read strobe
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regRdEn;
    end
  end

  // Flag view shows the value the status register takes next
  assign flagsNext = status_d[FLAG_COUNT-1:0];

  // Pin drive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinOe_q <= 1'b0;
      pinOut_q <= 1'b0;
    end else begin
      pinOe_q <= pinOe_d;
      pinOut_q <= 1'b0;           // Open drain: only ever low
    end
  end

  // Flag and pending views
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flagsOut_q <= '0;
      irqPending_q <= 1'b0;
    end else begin
      flagsOut_q <= flagsNext;
      irqPending_q <= pinOe_d;
    end
  end

  // Outputs straight from flip-flops
  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign trigIrqPinOut = pinOut_q;
  assign trigIrqPinOe = pinOe_q;
  assign flagsOut = flagsOut_q;
  assign irqPending = irqPending_q;

endmodule : sfim_status_irq

/* test/sfim_status_irq_props.sv */
`timescale 1ns/1ps
// Port checks for flags and pin drive
module sfim_status_irq_props
  import sfim_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched ports
  input wire logic regRdEn,
  input wire logic regRdValid,
  input wire logic sequencerDone,
  input wire logic formatError,
  input wire logic irqModeEn,
  input wire logic trigIrqPinOut,
  input wire logic trigIrqPinOe,
  input wire logic [sfim_pkg::FLAG_COUNT-1:0] flagsOut,
  input wire logic irqPending
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Properties
  property p_rd_ans; regRdValid == $past(regRdEn); endproperty
  property p_drive; !trigIrqPinOut && irqPending == trigIrqPinOe; endproperty
  property p_mode_off; !irqModeEn |=> !trigIrqPinOe; endproperty
  property p_idle; (flagsOut == '0)[*3] |-> !trigIrqPinOe; endproperty
  property p_done; sequencerDone |-> ##[1:2] flagsOut[3]; endproperty
  property p_fmt; formatError |-> ##[1:2] flagsOut[4]; endproperty
  property p_oe_why;
    $rose(trigIrqPinOe) |-> (|flagsOut) || $past(|flagsOut);
  endproperty
  property p_clear;
    |($past(flagsOut) & ~flagsOut) |->
      regRdEn || $past(regRdEn) || $past(regRdEn, 2);
  endproperty
  // Assertions
  a_rd_ans: assert property (p_rd_ans) else $error("bad read answer");
  a_drive: assert property (p_drive) else $error("bad pin drive");
  a_mode_off: assert property (p_mode_off) else $error("pin in io mode");
  a_idle: assert property (p_idle) else $error("pin with no flag");
  a_done: assert property (p_done) else $error("done not flagged");
  a_fmt: assert property (p_fmt) else $error("format not flagged");
  a_oe_why: assert property (p_oe_why) else $error("pin low cause");
  a_clear: assert property (p_clear) else $error("flag lost");
  // Main scenarios
  c_irq: cover property ($rose(trigIrqPinOe));
  c_rd: cover property (regRdEn ##1 regRdValid);
  c_clear: cover property ($fell(irqPending));
endmodule : sfim_status_irq_props

bind sfim_status_irq sfim_status_irq_props sfim_status_irq_props_i (
  .clock, .rst, .regRdEn, .regRdValid, .sequencerDone, .formatError,
  .irqModeEn, .trigIrqPinOut, .trigIrqPinOe, .flagsOut, .irqPending);

/* test/sfim_host_model.sv */
`timescale 1ns/1ps
// Host side of the register port
module sfim_host_model (
  // Clock
  input wire logic clock,
  // Strobes towards the device
  output logic [7:0] regAddr,
  output logic regWrEn,
  output logic [7:0] regWrData,
  output logic regRdEn
);
  // Idle bus
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'b0;
    regWrData = 8'h00;
    regRdEn = 1'b0;
  end
  // One-cycle write, data scrambled after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  // One-cycle read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
  endtask : rd
endmodule : sfim_host_model

/* test/tb_status_flags_and_irq_mask.sv */
`timescale 1ns/1ps
module tb_status_flags_and_irq_mask;
  import sfim_pkg::*;
  logic clock, rst, irqModeEn, playing, impValid, supValid;
  logic regWrEn, regRdEn, regRdValid, pinOut, pinOe, pend;
  logic [7:0] ev, impVal, supVal, regAddr, regWrData, rdData, m, e;
  logic [4:0] flags;
  logic irqExp;
  logic [7:0] expQ[$];
  int failCount = 0;
  int testsRun = 0;
  int b;
  // Device and host
  sfim_status_irq sfim_status_irq_i (.clock(clock), .rst(rst),
    .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData),
    .regRdEn(regRdEn), .regRdData(rdData), .regRdValid(regRdValid),
    .overcurrentDetect(ev[0]), .thermalDetect(ev[1]), .droopDetect(ev[2]),
    .sequencerDone(ev[3]), .formatError(ev[4]), .diagDone(ev[5]),
    .calibrationDone(ev[6]), .diagFail(ev[7]), .impedanceValue(impVal),
    .impedanceValid(impValid), .supplySample(supVal),
    .supplySampleValid(supValid), .waveformPlaying(playing),
    .irqModeEn(irqModeEn), .trigIrqPinOut(pinOut), .trigIrqPinOe(pinOe),
    .flagsOut(flags), .irqPending(pend));
  sfim_host_model sfim_host_model_i (.clock(clock), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    testsRun++;
    if (seen !== expv) begin
      failCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : chk
  // Verdict
  task automatic endSim;
    if (failCount == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : endSim
  // Note expectation, then read
  task automatic rdx(input logic [7:0] a, input logic [7:0] x);
    expQ.push_back(x);
    sfim_host_model_i.rd(a);
  endtask : rdx
  // Clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Read answers against oldest note
  always @(negedge clock) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        // Answer with no note counts as a mismatch
        chk(8'h01, 8'h00);
      end else begin
        chk(rdData, expQ.pop_front());
      end
    end
  end
  // Watchdog
  initial begin
    #100000;
    failCount++;
    endSim;
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    ev = 8'h00;
    irqModeEn = 1'b0;
    playing = 1'b0;
    impValid = 1'b0;
    supValid = 1'b0;
    impVal = 8'h00;
    supVal = 8'h00;
    m = 8'($urandom(70));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    rdx(OFS_MASK, RST_MASK);
    rdx(OFS_STATUS, 8'h00);
    rdx(OFS_IMPEDANCE, 8'h00);
    rdx(8'h05, 8'h00);
    sfim_host_model_i.wr(OFS_IMPEDANCE, 8'h5a);
    sfim_host_model_i.wr(OFS_SUPPLY, 8'ha5);
    sfim_host_model_i.wr(OFS_MASK, 8'he7);
    rdx(OFS_IMPEDANCE, 8'h00);
    rdx(OFS_SUPPLY, 8'h00);
    rdx(OFS_MASK, 8'he7);
    // Status writes reach only the reserved bits
    sfim_host_model_i.wr(OFS_STATUS, 8'hff);
    rdx(OFS_STATUS, 8'h60);
    sfim_host_model_i.wr(OFS_STATUS, 8'h00);
    rdx(OFS_STATUS, 8'h00);
    // A set in the read cycle wins over the clear
    ev[3] <= 1'b1;
    rdx(OFS_STATUS, 8'h08);
    rdx(OFS_STATUS, 8'h08);
    ev[3] <= 1'b0;
    rdx(OFS_STATUS, 8'h08);
    rdx(OFS_STATUS, 8'h00);
    supVal <= 8'($urandom);
    impVal <= 8'($urandom);
    supValid <= 1'b1;
    impValid <= 1'b1;
    @(posedge clock);
    impValid <= 1'b0;
    rdx(OFS_SUPPLY, 8'h00);
    rdx(OFS_IMPEDANCE, impVal);
    playing <= 1'b1;
    @(posedge clock);
    rdx(OFS_SUPPLY, supVal);
    playing <= 1'b0;
    // each source, masked, both pin modes
    for (int i = 0; i < 16; i++) begin
      b = i >> 1;
      m = 8'($urandom);
      e = (b == 5 || b == 6) ? 8'h08 : 8'h01 << b;
      sfim_host_model_i.wr(OFS_MASK, m);
      rdx(OFS_MASK, m);
      irqModeEn <= i[0];
      ev[b] <= 1'b1;
      repeat (6) @(posedge clock);
      ev[b] <= 1'b0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      irqExp = i[0] & |(e[4:0] & ~m[4:0]);
      chk({7'h0, pinOe}, {7'h0, irqExp});
      chk({7'h0, pend}, {7'h0, irqExp});
      chk({3'h0, flags}, {3'h0, e[4:0]});
      rdx(OFS_STATUS, e);
      rdx(OFS_STATUS, 8'h00);
      repeat (3) @(posedge clock);
      @(negedge clock);
      chk({7'h0, pinOe}, 8'h00);
      chk({7'h0, pend}, 8'h00);
    end
    chk(8'(expQ.size()), 8'h00);
    endSim;
  end
endmodule : tb_status_flags_and_irq_mask
